/* hw/amw_i2c_slave.sv */
// I2C register-access slave: pointer byte, writes with auto-increment, reads.
`timescale 1ns/10ps
`default_nettype none
module amw_i2c_slave import amw_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h0E
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output amw_regbus_s      o_bus,
  input  wire logic [7:0]  i_rd_data
);

  typedef struct packed {
    logic        scl1, scl2, sclp, sda1, sda2, sdap;
    amw_i2c_e    st;
    logic [7:0]  sh;
    logic [3:0]  bitc;
    logic [7:0]  ptr;
    logic        first;
    logic        rw;
    logic        nack;
    logic        oe;
    amw_regbus_s bus;
  } amw_i2c_s;

  amw_i2c_s r, n;
  logic rise, fall, start, stop;

  always_comb begin
    n = r;
    n.scl1 = i_scl;
    n.scl2 = r.scl1;
    n.sda1 = i_sda;
    n.sda2 = r.sda1;
    n.sclp = r.scl2;
    n.sdap = r.sda2;
    n.bus.wr = 1'b0;
    n.bus.rd = 1'b0;
    rise  = r.scl2 & ~r.sclp;
    fall  = ~r.scl2 & r.sclp;
    start = r.scl2 & r.sclp & r.sdap & ~r.sda2;
    stop  = r.scl2 & r.sclp & ~r.sdap & r.sda2;
    if (start) begin
      n.st = I2C_ADDR;
      n.bitc = 4'h0;
      n.oe = 1'b0;
    end else if (stop) begin
      n.st = I2C_IDLE;
      n.oe = 1'b0;
    end else begin
      case (r.st)
        I2C_ADDR, I2C_WBYTE: begin
          if (rise) begin
            n.sh = {r.sh[6:0], r.sda2};
            n.bitc = r.bitc + 4'h1;
          end else if (fall && r.bitc == 4'h8) begin
            n.oe = 1'b1;
            if (r.st == I2C_ADDR) begin
              n.rw = r.sh[0];
              n.st = (r.sh[7:1] == DEV_ADDR) ? I2C_ACK_A : I2C_IDLE;
              n.oe = (r.sh[7:1] == DEV_ADDR);
              n.first = 1'b1;
            end else begin
              n.st = I2C_ACK_W;
              if (r.first) begin
                n.ptr = r.sh;
                n.bus.addr = r.sh;
                n.first = 1'b0;
              end else begin
                n.bus.wr = 1'b1;
                n.bus.addr = r.ptr;
                n.bus.wdata = r.sh;
                n.ptr = r.ptr + 8'h1;
              end
            end
          end
        end
        I2C_ACK_A, I2C_ACK_W: begin
          if (fall) begin
            n.bitc = 4'h0;
            n.oe = 1'b0;
            n.st = I2C_WBYTE;
            if (r.st == I2C_ACK_A && r.rw) begin
              n.st = I2C_RBYTE;
              n.oe = ~i_rd_data[7];
              n.sh = {i_rd_data[6:0], 1'b0};
              n.bus.rd = 1'b1;
              n.bus.addr = r.ptr;
              n.ptr = r.ptr + 8'h1;
            end
          end
        end
        I2C_RBYTE: begin
          if (fall) begin
            if (r.bitc == 4'h7) begin
              n.oe = 1'b0;
              n.st = I2C_RACK;
              // Point the read mux at the next register before its byte is loaded.
              n.bus.addr = r.ptr;
            end else begin
              n.oe = ~r.sh[7];
              n.sh = {r.sh[6:0], 1'b0};
              n.bitc = r.bitc + 4'h1;
            end
          end
        end
        I2C_RACK: begin
          if (rise) begin
            n.nack = r.sda2;
          end else if (fall) begin
            n.st = I2C_IDLE;
            if (!r.nack) begin
              n.st = I2C_RBYTE;
              n.bitc = 4'h0;
              n.oe = ~i_rd_data[7];
              n.sh = {i_rd_data[6:0], 1'b0};
              n.bus.rd = 1'b1;
              n.bus.addr = r.ptr;
              n.ptr = r.ptr + 8'h1;
            end
          end
        end
        default: n.st = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '{scl1: 1'b1, scl2: 1'b1, sclp: 1'b1, sda1: 1'b1, sda2: 1'b1,
             sdap: 1'b1, st: I2C_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = r.oe;
  assign o_bus     = r.bus;

endmodule
`default_nettype wire

/* hw/amw_motion_core.sv */
// Motion wake-up control: registers, persistence engine and interrupt pin.
//
// Functional notes
// - Writing one to reboot bit starts reboot; bit reads one until done.
// - Check bit makes response read 0xAA; reading response clears bit, gives 0x55.
// - Three-bit wake code sets sample rate, 0.781 Hz doubling to 100 Hz.
// - Pin enable bit gates the physical interrupt output.
// - Polarity bit: zero active low, one active high; resets active high.
// - Pulse-mode bit zero latches pin until release read; one gives short pulse.
// - Six enables, bits 5..0: x-, x+, y-, y+, z-, z+; all on at reset.
// - Four-bit output rate code; filter roll-off is half the rate.
// - Output rate of 400 Hz or more forces full-power operation.
// - Persistence count holds sample periods of motion; host programs 1 to 255.
// - Writing 0xCA to self-test actuates sense element; 0x00 returns to normal.
// - Motion level scaled 16 counts per g; resets to 8.
// - Motion event when enabled direction exceeds level for the persistence count.
// - Events always latch; pulse mode pulses once until release is read.
// - Reading release clears latched sources and returns latched pin inactive.
// - Motion engine runs only while its enable bit is set.
// - Triggering axis and direction recorded in six flags at 0x17.
// - Run bit: zero standby, one active measurement.
`timescale 1ns/10ps
`default_nettype none
module amw_motion_core import amw_pkg::*; #(
  parameter logic [6:0] DEV_ADDR   = 7'h0E,
  parameter int         WAKE_CYC   = WAKE_BASE_CYC,
  parameter int         PULSE_LEN  = PULSE_CYC,
  parameter int         REBOOT_LEN = REBOOT_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire amw_axes_s  i_axes,
  output logic            o_int,
  output logic            o_run,
  output logic            o_full_power,
  output logic [3:0]      o_lpf_rate,
  output logic            o_sense_actuate,
  output logic            o_reboot_busy,
  output logic            o_wake_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic       run;
    logic       res;
    logic       detect_on;
    logic       reboot;
    logic       check;
    logic [2:0] wake_rate;
    logic       irq_on;
    logic       irq_pol;
    logic       irq_pulse;
    logic [5:0] dir_en;
    logic [3:0] rate;
    logic [7:0] persist;
    logic [7:0] selftest;
    logic [7:0] level;
    logic       evt;
    logic [5:0] src;
    logic [7:0] cnt;
    logic       fired;
    logic [9:0] pulse_cnt;
    logic [4:0] reboot_cnt;
    logic       pin;
    logic       full_power;
  } amw_core_s;

  amw_core_s   r, n;
  amw_regbus_s bus;
  logic [7:0]  rd_data;
  logic        tick;
  logic [5:0]  hit;
  logic        released;
  logic        new_evt;
  logic        act;
  logic [AXIS_W-1:0] ax [3];

  assign ax[0] = i_axes.x;
  assign ax[1] = i_axes.y;
  assign ax[2] = i_axes.z;

  ////////////////////////////////////////////////////////////////////////////
  // Host access and wake-up rate divider.

  amw_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .i_mclk    (i_mclk),
    .i_resetn  (i_resetn),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda_out (o_sda_out),
    .o_sda_oe  (o_sda_oe),
    .o_bus     (bus),
    .i_rd_data (rd_data)
  );

  amw_rate_tick #(
    .BASE_CYC (WAKE_CYC)
  ) u_tick (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_run    (r.run & r.detect_on),
    .i_code   (r.wake_rate),
    .o_tick   (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux.

  always_comb begin
    rd_data = 8'h00;
    if (bus.addr == ADR_RESPONSE) begin
      rd_data = r.check ? RESP_CHECK : RESP_IDLE;
    end else if (bus.addr == ADR_EVT_SRC) begin
      rd_data[EVT_BIT] = r.evt;
    end else if (bus.addr == ADR_DIR_SRC) begin
      rd_data = {2'b00, r.src};
    end else if (bus.addr == ADR_CTRL1) begin
      rd_data[CTRL1_RUN] = r.run;
      rd_data[CTRL1_RES] = r.res;
      rd_data[CTRL1_DETECT] = r.detect_on;
    end else if (bus.addr == ADR_CTRL2) begin
      rd_data[CTRL2_REBOOT] = r.reboot;
      rd_data[CTRL2_CHECK] = r.check;
      rd_data[2:0] = r.wake_rate;
    end else if (bus.addr == ADR_IRQ_CTRL) begin
      rd_data[IRQ_ON] = r.irq_on;
      rd_data[IRQ_POL] = r.irq_pol;
      rd_data[IRQ_PULSE] = r.irq_pulse;
    end else if (bus.addr == ADR_DIR_EN) begin
      rd_data = {2'b00, r.dir_en};
    end else if (bus.addr == ADR_RATE) begin
      rd_data = {4'h0, r.rate};
    end else if (bus.addr == ADR_PERSIST) begin
      rd_data = r.persist;
    end else if (bus.addr == ADR_SELFTEST) begin
      rd_data = r.selftest;
    end else if (bus.addr == ADR_LEVEL) begin
      rd_data = r.level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic signed [AXIS_W:0] v;
    logic signed [AXIS_W:0] lvl;
    v = '0;
    lvl = $signed({{(AXIS_W-7){1'b0}}, r.level});
    n = r;
    hit = '0;
    new_evt = 1'b0;
    released = bus.rd && bus.addr == ADR_RELEASE;

    // Each axis contributes a minus and a plus direction, x first.
    for (int i = 0; i < 3; i++) begin
      v = $signed({ax[i][AXIS_W-1], ax[i]});
      hit[5-2*i] = v < -lvl;
      hit[4-2*i] = v > lvl;
    end
    hit = hit & r.dir_en;

    // Register writes. The host keeps the device in standby while it
    // reconfigures; writes are not blocked here.
    if (bus.wr) begin
      if (bus.addr == ADR_CTRL1) begin
        n.run = bus.wdata[CTRL1_RUN];
        n.res = bus.wdata[CTRL1_RES];
        n.detect_on = bus.wdata[CTRL1_DETECT];
      end else if (bus.addr == ADR_CTRL2) begin
        n.wake_rate = bus.wdata[2:0];
        if (bus.wdata[CTRL2_REBOOT]) begin
          n.reboot = 1'b1;
          n.reboot_cnt = 5'(REBOOT_LEN);
        end
        if (bus.wdata[CTRL2_CHECK]) begin
          n.check = 1'b1;
        end
      end else if (bus.addr == ADR_IRQ_CTRL) begin
        n.irq_on = bus.wdata[IRQ_ON];
        n.irq_pol = bus.wdata[IRQ_POL];
        n.irq_pulse = bus.wdata[IRQ_PULSE];
      end else if (bus.addr == ADR_DIR_EN) begin
        n.dir_en = bus.wdata[5:0];
      end else if (bus.addr == ADR_RATE) begin
        n.rate = bus.wdata[3:0];
      end else if (bus.addr == ADR_PERSIST) begin
        n.persist = bus.wdata;
      end else if (bus.addr == ADR_SELFTEST) begin
        n.selftest = bus.wdata;
      end else if (bus.addr == ADR_LEVEL) begin
        n.level = bus.wdata;
      end
    end

    // Reading the response byte ends the communication check.
    if (bus.rd && bus.addr == ADR_RESPONSE) begin
      n.check = 1'b0;
    end

    // Release clears the latched sources; a same-cycle event sets below.
    if (released) begin
      n.evt = 1'b0;
      n.src = '0;
      n.fired = 1'b0;
    end

    // Persistence engine, stepped once per wake-up sample.
    if (!(r.run && r.detect_on)) begin
      n.cnt = '0;
    end else if (tick) begin
      if (hit != 6'h00) begin
        // A zero count is not valid; it behaves as one sample.
        if (r.cnt + 8'h1 >= r.persist) begin
          n.cnt = '0;
          new_evt = 1'b1;
        end else begin
          n.cnt = r.cnt + 8'h1;
        end
      end else begin
        n.cnt = '0;
      end
    end

    if (new_evt) begin
      n.evt = 1'b1;
      n.src = (released ? 6'h00 : r.src) | hit;
    end

    // Pulse mode fires once per latched event until released.
    if (r.pulse_cnt != '0) begin
      n.pulse_cnt = r.pulse_cnt - 10'h1;
    end
    if (new_evt && r.irq_pulse && (released || !r.fired)) begin
      n.pulse_cnt = 10'(PULSE_LEN);
      n.fired = 1'b1;
    end

    // Reboot runs for a fixed time, then restores the configuration except the CTRL1 run, resolution and detect bits.
    if (r.reboot && !(bus.wr && bus.addr == ADR_CTRL2)) begin
      if (r.reboot_cnt != '0) begin
        n.reboot_cnt = r.reboot_cnt - 5'h1;
      end else begin
        n.reboot = 1'b0;
        n.check = 1'b0;
        n.wake_rate = '0;
        n.irq_on = RST_IRQ_CTRL[IRQ_ON];
        n.irq_pol = RST_IRQ_CTRL[IRQ_POL];
        n.irq_pulse = RST_IRQ_CTRL[IRQ_PULSE];
        n.dir_en = RST_DIR_EN;
        n.rate = RST_RATE;
        n.persist = RST_PERSIST;
        n.selftest = RST_SELFTEST;
        n.level = RST_LEVEL;
      end
    end

    // Pin: inactive level when disabled, otherwise the selected level.
    act = r.irq_pulse ? (r.pulse_cnt != '0) : r.evt;
    n.pin = (r.irq_on && act) ? r.irq_pol : ~r.irq_pol;

    n.full_power = r.run && (r.res ||
                   (r.rate >= RATE_FULL_LO && r.rate <= RATE_FULL_HI));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '{irq_on: RST_IRQ_CTRL[IRQ_ON], irq_pol: RST_IRQ_CTRL[IRQ_POL],
             irq_pulse: RST_IRQ_CTRL[IRQ_PULSE], dir_en: RST_DIR_EN,
             rate: RST_RATE, persist: RST_PERSIST, selftest: RST_SELFTEST,
             level: RST_LEVEL, default: '0};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign o_int           = r.pin;
  assign o_run           = r.run;
  assign o_full_power    = r.full_power;
  assign o_lpf_rate      = r.rate;
  assign o_sense_actuate = r.selftest == UNLOCK_CODE;
  assign o_reboot_busy   = r.reboot;
  assign o_wake_tick     = tick;

endmodule
`default_nettype wire

/* hw/amw_pkg.sv */
// Shared constants and types for the motion wake-up control block.
package amw_pkg;

  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_NS        = 40;
  localparam int WAKE_TOP_HZ   = 100;
  localparam int WAKE_BASE_CYC = CLK_HZ / WAKE_TOP_HZ;
  localparam int PULSE_MIN_NS  = 30_000;
  localparam int PULSE_MAX_NS  = 50_000;
  localparam int PULSE_CYC     = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int REBOOT_CYC    = 16;

  localparam logic [7:0] ADR_RESPONSE = 8'h0C;
  localparam logic [7:0] ADR_EVT_SRC  = 8'h16;
  localparam logic [7:0] ADR_DIR_SRC  = 8'h17;
  localparam logic [7:0] ADR_RELEASE  = 8'h1A;
  localparam logic [7:0] ADR_CTRL1    = 8'h1B;
  localparam logic [7:0] ADR_CTRL2    = 8'h1C;
  localparam logic [7:0] ADR_IRQ_CTRL = 8'h1D;
  localparam logic [7:0] ADR_DIR_EN   = 8'h1F;
  localparam logic [7:0] ADR_RATE     = 8'h21;
  localparam logic [7:0] ADR_PERSIST  = 8'h29;
  localparam logic [7:0] ADR_SELFTEST = 8'h3A;
  localparam logic [7:0] ADR_LEVEL    = 8'h6A;

  localparam int CTRL1_RUN    = 7;
  localparam int CTRL1_RES    = 6;
  localparam int CTRL1_DETECT = 1;
  localparam int CTRL2_REBOOT = 7;
  localparam int CTRL2_CHECK  = 4;
  localparam int IRQ_ON       = 5;
  localparam int IRQ_POL      = 4;
  localparam int IRQ_PULSE    = 3;
  localparam int EVT_BIT      = 1;

  localparam logic [7:0] RST_IRQ_CTRL = 8'h10;
  localparam logic [5:0] RST_DIR_EN   = 6'h3F;
  localparam logic [3:0] RST_RATE     = 4'h2;
  localparam logic [7:0] RST_PERSIST  = 8'h00;
  localparam logic [7:0] RST_SELFTEST = 8'h00;
  localparam logic [7:0] RST_LEVEL    = 8'h08;
  localparam logic [7:0] RESP_IDLE    = 8'h55;
  localparam logic [7:0] RESP_CHECK   = 8'hAA;
  localparam logic [7:0] UNLOCK_CODE  = 8'hCA;
  localparam logic [3:0] RATE_FULL_LO = 4'h5;
  localparam logic [3:0] RATE_FULL_HI = 4'h7;
  localparam logic [2:0] WAKE_CODE_MAX = 3'h7;

  localparam int AXIS_W = 12;

  typedef struct packed {
    logic [AXIS_W-1:0] x;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] z;
  } amw_axes_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amw_regbus_s;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_WBYTE, I2C_ACK_W, I2C_RBYTE, I2C_RACK
  } amw_i2c_e;

endpackage

/* hw/amw_rate_tick.sv */
// Wake-up sample-rate divider: one-cycle tick at base rate for code 7, halved per code step below 7.
`timescale 1ns/10ps
`default_nettype none
module amw_rate_tick import amw_pkg::*; #(
  parameter int BASE_CYC = WAKE_BASE_CYC,
  parameter int CNT_W    = 26
) (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_run,
  input  wire logic [2:0] i_code,
  output logic            o_tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } amw_tick_s;

  amw_tick_s r, n;
  logic [CNT_W-1:0] period;

  always_comb begin
    period = CNT_W'(BASE_CYC) << (WAKE_CODE_MAX - i_code);
    n = r;
    n.tick = 1'b0;
    if (!i_run) begin
      n.cnt = '0;
    end else if (r.cnt >= period - CNT_W'(1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_tick = r.tick;

endmodule
`default_nettype wire

/* test/amw_i2c_host.sv */
// Behavioural I2C host that writes and reads the block's registers.
`timescale 1ns/10ps
`default_nettype none
module amw_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h0E
) (
  input  wire logic       i_mclk,
  input  wire logic       i_sda_line,
  output logic            o_scl,
  output logic            o_sda,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data,
  output logic            o_nack
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_rd_valid = 1'b0;
    o_rd_data = 8'h00;
    o_nack = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic sc(input logic c, input logic d);
    o_scl = c;
    o_sda = d;
    hp(6);
  endtask
  // SDA moves only while SCL is low; the line is read late in the high phase.
  task automatic bit_x(input logic b, output logic s);
    sc(1'b0, b);
    o_scl = 1'b1;
    hp(5);
    s = i_sda_line;
    hp(1);
    o_scl = 1'b0;
    hp(2);
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
      q[i] = s;
    end
    bit_x(1'b1, a);
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    byte_x(d, q, a);
    if (a) o_nack = 1'b1;
  endtask
  task automatic start;
    sc(o_scl, 1'b1);
    sc(1'b1, 1'b1);
    sc(1'b1, 1'b0);
    sc(1'b0, 1'b0);
  endtask
  task automatic stop;
    sc(1'b0, 1'b0);
    sc(1'b1, 1'b0);
    sc(1'b1, 1'b1);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    start();
    send({DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask
  task automatic reg_read(input logic [7:0] a);
    logic [7:0] q;
    logic       n;
    start();
    send({DEV_ADDR, 1'b0});
    send(a);
    start();
    send({DEV_ADDR, 1'b1});
    byte_x(8'hFF, q, n);
    stop();
    o_rd_data = q;
    o_rd_valid = 1'b1;
    hp(1);
    o_rd_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/amw_motion_core_bench.sv */
// Self-checking bench for the motion wake-up control block.
`timescale 1ns/10ps
`default_nettype none
module amw_motion_core_bench import amw_pkg::*; ();
  logic       i_mclk;
  logic       i_resetn;
  amw_axes_s  axes;
  logic       scl, sda_h, sda_out, sda_oe, int_pin, run, fp, act, busy, tick, rd_v, nack;
  logic [3:0] lpf;
  logic [7:0] rd_d;
  logic [8:0] ent;
  logic [8:0] exp_q[$];
  int         n_fail, total_checks, seed, k, g;
  wire logic  sda_line;
  logic [7:0] ra [9] = '{ADR_IRQ_CTRL, ADR_DIR_EN, ADR_RATE, ADR_PERSIST, ADR_SELFTEST,
                         ADR_LEVEL, ADR_CTRL2, ADR_RESPONSE, 8'h40};
  logic [7:0] rv [9] = '{8'h10, 8'h3F, 8'h02, 8'h00, 8'h00, 8'h08, 8'h00, 8'h55, 8'h00};
  // Open-drain data line with a pull-up.
  assign sda_line = sda_h & ~(sda_oe & ~sda_out);
  initial i_mclk = 1'b0;
  always #20 i_mclk = ~i_mclk;
  amw_motion_core #(.WAKE_CYC(8), .PULSE_LEN(4), .REBOOT_LEN(16)) dut_u (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_axes(axes), .o_int(int_pin),
    .o_run(run), .o_full_power(fp), .o_lpf_rate(lpf), .o_sense_actuate(act),
    .o_reboot_busy(busy), .o_wake_tick(tick));
  amw_i2c_host host_u (.i_mclk(i_mclk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(sda_h),
    .o_rd_valid(rd_v), .o_rd_data(rd_d), .o_nack(nack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.reg_write(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({1'b1, e});
    host_u.reg_read(a);
  endtask
  task automatic rx(input logic [7:0] a);
    exp_q.push_back(9'h000);
    host_u.reg_read(a);
  endtask
  task automatic quiet;
    axes.x = 12'h008;
    axes.y = 12'hFF8;
    axes.z = 12'($random(seed) % 8);
  endtask
  task automatic trig(input logic [7:0] irq);
    wr(ADR_CTRL1, 8'h00);
    wr(ADR_IRQ_CTRL, irq);
    wr(ADR_CTRL1, 8'h82);
    // Motion starts only once the write is over, so a short pulse is not missed.
    axes.x = 12'h014;
    axes.y = 12'hF9C;
  endtask
  task automatic gap(input int lim);
    g = 0;
    do begin
      @(negedge i_mclk);
      g++;
    end while (tick !== 1'b1 && g < lim);
  endtask
  task automatic hold(input logic lv);
    g = 0;
    while (int_pin === lv && g < 400) begin
      @(negedge i_mclk);
      g++;
    end
  endtask
  // Read results are compared against the oldest note as they come back, except where that note was queued by rx.
  always @(posedge i_mclk) begin
    if (rd_v === 1'b1) begin
      ent = exp_q.pop_front();
      if (ent[8]) check("register", 16'(rd_d), 16'(ent[7:0]));
    end
  end
  initial begin
    repeat (95000) @(negedge i_mclk);
    n_fail++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 16;
    n_fail = 0;
    total_checks = 0;
    i_resetn = 1'b0;
    axes = '0;
    repeat (4) @(negedge i_mclk);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_mclk);
    check("pin idle", 16'(int_pin), 16'h0000);
    for (k = 0; k < 9; k++) rd(ra[k], rv[k]);
    wr(ADR_CTRL2, 8'h10);
    rd(ADR_RESPONSE, 8'hAA);
    rd(ADR_CTRL2, 8'h00);
    rd(ADR_RESPONSE, 8'h55);
    for (k = 0; k < 12; k++) begin
      wr(ADR_CTRL1, 8'h00);
      wr(ADR_RATE, 8'(k));
      wr(ADR_CTRL1, 8'h80);
      check("rate", 16'(lpf), 16'(k));
      check("full", 16'(fp), 16'(k >= 5 && k <= 7));
      check("run", 16'(run), 16'h0001);
    end
    wr(ADR_CTRL1, 8'h00);
    check("run", 16'(run), 16'h0000);
    wr(ADR_SELFTEST, 8'hCB);
    check("act", 16'(act), 16'h0000);
    wr(ADR_SELFTEST, 8'hCA);
    check("act", 16'(act), 16'h0001);
    wr(ADR_SELFTEST, 8'h00);
    check("act", 16'(act), 16'h0000);
    for (k = 0; k < 8; k++) begin
      wr(ADR_CTRL1, 8'h00);
      wr(ADR_CTRL2, 8'(k));
      wr(ADR_CTRL1, 8'h82);
      gap(3000);
      gap(3000);
      check("tick", 16'(g), 16'(8 << (7 - k)));
    end
    wr(ADR_CTRL1, 8'h80);
    gap(3000);
    check("no tick", 16'(g), 16'(3000));
    wr(ADR_CTRL1, 8'h00);
    wr(ADR_PERSIST, 8'h03);
    wr(ADR_DIR_EN, 8'h10);
    quiet();
    trig(8'h30);
    hold(1'b0);
    check("event", 16'(int_pin), 16'h0001);
    quiet();
    rd(ADR_EVT_SRC, 8'h02);
    rd(ADR_DIR_SRC, 8'h10);
    check("latched", 16'(int_pin), 16'h0001);
    rx(ADR_RELEASE);
    check("released", 16'(int_pin), 16'h0000);
    rd(ADR_DIR_SRC, 8'h00);
    trig(8'h38);
    hold(1'b0);
    hold(1'b1);
    check("pulse", 16'(g), 16'h0004);
    repeat (200) @(negedge i_mclk);
    check("once", 16'(int_pin), 16'h0000);
    quiet();
    rx(ADR_RELEASE);
    trig(8'h28);
    hold(1'b1);
    check("low act", 16'(int_pin), 16'h0000);
    quiet();
    rx(ADR_RELEASE);
    check("low idle", 16'(int_pin), 16'h0001);
    trig(8'h00);
    repeat (100) @(negedge i_mclk);
    check("pin off", 16'(int_pin), 16'h0001);
    quiet();
    rd(ADR_EVT_SRC, 8'h02);
    rx(ADR_RELEASE);
    wr(ADR_CTRL1, 8'h00);
    wr(ADR_IRQ_CTRL, 8'h30);
    wr(ADR_CTRL1, 8'h82);
    for (k = 0; k < 12; k++) begin
      gap(100);
      axes.x = (k % 3 == 2) ? 12'h008 : 12'h014;
    end
    gap(100);
    quiet();
    check("restart", 16'(int_pin), 16'h0000);
    wr(ADR_CTRL1, 8'h00);
    wr(ADR_DIR_EN, 8'h05);
    wr(ADR_CTRL2, 8'h80);
    check("busy", 16'(busy), 16'h0000);
    rd(ADR_DIR_EN, 8'h3F);
    rd(ADR_RATE, 8'h02);
    rd(ADR_CTRL2, 8'h00);
    check("nack", 16'(nack), 16'h0000);
    repeat (4) @(negedge i_mclk);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* test/amw_motion_sva.sv */
// Port-level assertions for the motion wake-up control block.
`timescale 1ns/10ps
`default_nettype none
module amw_motion_sva #(
  parameter int REBOOT_LEN = 16
) (
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic       o_sda_oe,
  input wire logic       o_run,
  input wire logic       o_full_power,
  input wire logic [3:0] o_lpf_rate,
  input wire logic       o_sense_actuate,
  input wire logic       o_reboot_busy,
  input wire logic       o_wake_tick
);
  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  // Counts the cycles of the current reboot so its length can be judged when it ends.
  always_comb busy_cnt_nxt = o_reboot_busy ? busy_cnt_r + 8'h01 : 8'h00;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_cnt_r <= 8'h00;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_tick_spacing: assert property (o_wake_tick |=> !o_wake_tick [*7])
    else $error("wake ticks closer than eight cycles");
  a_tick_needs_run: assert property (o_wake_tick |-> o_run || $past(o_run))
    else $error("wake tick while stopped");
  a_standby_low_power: assert property (!o_run && !$past(o_run) && !$past(o_run, 2)
    |-> !o_full_power)
    else $error("full power while in standby");
  a_fast_rate_power: assert property (o_run && $past(o_run) && $stable(o_lpf_rate)
    && o_lpf_rate >= 4'h5 && o_lpf_rate <= 4'h7 |-> o_full_power)
    else $error("fast rate without full power");
  a_reboot_length: assert property ($fell(o_reboot_busy)
    |-> busy_cnt_r == 8'(REBOOT_LEN + 1))
    else $error("reboot length wrong");
  a_reboot_bound: assert property (busy_cnt_r <= 8'(REBOOT_LEN + 1))
    else $error("reboot runs too long");
  a_reboot_by_write: assert property ($rose(o_reboot_busy) |-> o_sda_oe)
    else $error("reboot started without a write");
  a_rate_by_write: assert property ($changed(o_lpf_rate) |-> o_sda_oe || o_reboot_busy
    || $past(o_reboot_busy) || $past(o_reboot_busy, 2))
    else $error("rate code changed without a write");
  a_actuate_by_write: assert property ($changed(o_sense_actuate) |-> o_sda_oe
    || $past(o_reboot_busy) || $past(o_reboot_busy, 2))
    else $error("actuation changed without a write");
endmodule
bind amw_motion_core amw_motion_sva #(.REBOOT_LEN(REBOOT_LEN)) chk_u (
  .i_mclk         (i_mclk),
  .i_resetn       (i_resetn),
  .o_sda_oe       (o_sda_oe),
  .o_run          (o_run),
  .o_full_power   (o_full_power),
  .o_lpf_rate     (o_lpf_rate),
  .o_sense_actuate(o_sense_actuate),
  .o_reboot_busy  (o_reboot_busy),
  .o_wake_tick    (o_wake_tick)
);
`default_nettype wire
